// File: hdl/csw_portable_terminal.sv
// portable end of the cipher mode switch handshake
`timescale 1ns/10ps
module csw_portable_terminal (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // frame timing from the burst controller
   input wire logic frame_tick,
   input wire logic half_tick,
   input wire logic [csw_pkg::FRAME_W-1:0] frame_num,
   input wire logic [csw_pkg::MFRAME_W-1:0] mframe_num,
   // upper-layer primitives
   input wire logic mode_switch_request_prim,
   input wire logic mode_switch_to_enc,
   output logic mode_switch_confirm_prim,
   output logic disconnect_indication_prim,
   // cipher steering for this connection
   output logic tx_encrypt,
   output logic rx_decrypt,
   output logic rx_discard,
   output logic switch_busy,
   output logic conn_released,
   output logic [csw_pkg::IV_W-1:0] keystream_iv,
   // air link
   csw_link_if.portable_terminal link
);

   typedef enum logic [1:0] {
      st_idle,
      st_wait_req,
      st_requesting,
      st_granting
   } csw_pt_state_e;

   csw_pt_state_e state_q;
   csw_pt_state_e state_d;
   logic target_q;
   logic [csw_pkg::CNT_W-1:0] cnt_q;
   logic tx_enc_q;
   logic rx_dec_q;
   logic discard_q;
   logic released_q;
   logic cfm_q;
   logic busy_q;
   logic dis_q;
   logic msg_vld_q;
   csw_pkg::csw_msg_e msg_q;
   logic [csw_pkg::IV_W-1:0] iv_q;

   // decoded frame events
   wire frame_even = ~frame_num[csw_pkg::PARITY_BIT];
   wire even_start = frame_tick & frame_even;
   wire even_send = half_tick & frame_even;
   wire req_take = mode_switch_request_prim & (state_q == st_idle)
                   & ~released_q;
   // confirms only counted in odd frames
   wire conf_seen = link.ft_msg_vld
                    & (link.ft_msg == csw_pkg::conf_msg(target_q))
                    & frame_num[csw_pkg::PARITY_BIT];
   wire conf_hit = (state_q == st_requesting) & conf_seen;
   wire tries_out = (cnt_q == csw_pkg::PT_REQ_MAX);
   wire give_up = (state_q == st_requesting) & even_send & tries_out
                  & ~conf_seen;
   wire send_req = (state_q != st_idle) & (state_q != st_granting)
                   & even_send & ~tries_out & ~conf_hit;
   wire send_grant = (state_q == st_granting) & even_send;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         st_idle: begin
            // only this end starts a switch
            if (req_take) begin
               state_d = st_wait_req;
            end
         end
         st_wait_req: begin
            if (send_req) begin
               state_d = st_requesting;
            end
         end
         st_requesting: begin
            if (conf_hit) begin
               state_d = st_granting;
            end else if (give_up) begin
               state_d = st_idle;
            end
         end
         st_granting: begin
            if (send_grant) begin
               state_d = st_idle;
            end
         end
      endcase
   end

   // busy kept in a flop so the output carries no decode
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_q <= st_idle;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         busy_q <= (state_d != st_idle);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         target_q <= 1'b0;
      end else if (req_take) begin
         target_q <= mode_switch_to_enc;
      end
   end

   // count requests sent, up to five
   always_ff @(posedge clk_sys) begin
      if (srst || req_take) begin
         cnt_q <= csw_pkg::CNT_ZERO;
      end else if (send_req) begin
         cnt_q <= cnt_q + csw_pkg::CNT_ONE;
      end
   end

   // message out only in second half of even frames
   // carried as a control-type T-field message
   // sent beside the cipher path, always clear
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         msg_vld_q <= 1'b0;
         msg_q <= csw_pkg::msg_start_req;
      end else begin
         msg_vld_q <= send_req | send_grant;
         if (send_req) begin
            msg_q <= csw_pkg::req_msg(target_q);
         end else if (send_grant) begin
            msg_q <= csw_pkg::grant_msg(target_q);
         end
      end
   end

   // receive mode flips on the confirm itself
   // stop confirm field already read as clear
   // one mode shared by every bearer
   always_ff @(posedge clk_sys) begin
      if (srst || give_up) begin
         rx_dec_q <= 1'b0;
      end else if (conf_hit) begin
         rx_dec_q <= target_q;
      end
   end

   // transmit mode follows from the grant frame
   // clear from the stop grant frame onward
   always_ff @(posedge clk_sys) begin
      if (srst || give_up) begin
         tx_enc_q <= 1'b0;
      end else if ((state_q == st_granting) && even_start) begin
         tx_enc_q <= target_q;
      end
   end

   // discard from first request until confirm
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         discard_q <= 1'b0;
      end else if (conf_hit || give_up) begin
         discard_q <= 1'b0;
      end else if (send_req) begin
         discard_q <= 1'b1;
      end
   end

   // released link stays down until reset
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         released_q <= 1'b0;
      end else if (give_up) begin
         released_q <= 1'b1;
      end
   end

   // confirm reported upward as a pulse
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cfm_q <= 1'b0;
         dis_q <= 1'b0;
      end else begin
         cfm_q <= conf_hit;
         dis_q <= give_up;
      end
   end

   // reload value per frame: frame, multiframe, zero
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         iv_q <= '0;
      end else if (frame_tick) begin
         iv_q <= {csw_pkg::IV_PAD, mframe_num, frame_num};
      end
   end

   // upper layer re-requests encryption after handover
   assign mode_switch_confirm_prim = cfm_q;
   assign disconnect_indication_prim = dis_q;
   assign tx_encrypt = tx_enc_q;
   assign rx_decrypt = rx_dec_q;
   assign rx_discard = discard_q;
   assign switch_busy = busy_q;
   assign conn_released = released_q;
   assign keystream_iv = iv_q;
   assign link.pt_msg_vld = msg_vld_q;
   assign link.pt_msg = msg_q;

endmodule

// File: hdl/csw_pkg.sv
// shared constants and types for the cipher mode switch handshake
package csw_pkg;

   // frame and multiframe number widths
   localparam int unsigned FRAME_W = 4;
   localparam int unsigned MFRAME_W = 24;
   // keystream initial value: frame, multiframe, zero pad
   localparam int unsigned IV_W = 35;
   localparam int unsigned IV_PAD_W = IV_W - FRAME_W - MFRAME_W;
   localparam logic [IV_PAD_W-1:0] IV_PAD = '0;

   // frame parity bit, even when clear
   localparam int unsigned PARITY_BIT = 0;

   // retry counts
   localparam int unsigned CNT_W = 3;
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
   // portable end: requests in five even frames
   localparam logic [CNT_W-1:0] PT_REQ_MAX = 3'h5;
   // fixed end: confirms in odd frames 2S+1 .. 2S+11
   localparam logic [CNT_W-1:0] FT_CONF_MAX = 3'h6;

   // mode-switch control messages on the link
   typedef enum logic [2:0] {
      msg_start_req,
      msg_start_grant,
      msg_stop_req,
      msg_stop_grant,
      msg_on_confirm,
      msg_off_confirm
   } csw_msg_e;

   // request message for a target mode
   function automatic csw_msg_e req_msg(input logic to_enc);
      return to_enc ? msg_start_req : msg_stop_req;
   endfunction

   // grant message for a target mode
   function automatic csw_msg_e grant_msg(input logic to_enc);
      return to_enc ? msg_start_grant : msg_stop_grant;
   endfunction

   // confirm message for a target mode
   function automatic csw_msg_e conf_msg(input logic to_enc);
      return to_enc ? msg_on_confirm : msg_off_confirm;
   endfunction

endpackage

// File: hdl/csw_link_if.sv
// link between portable and fixed ends: mode-switch messages
`timescale 1ns/10ps
interface csw_link_if;
   // portable to fixed
   logic pt_msg_vld;
   csw_pkg::csw_msg_e pt_msg;
   // fixed to portable
   logic ft_msg_vld;
   csw_pkg::csw_msg_e ft_msg;

   modport portable_terminal (
      output pt_msg_vld,
      output pt_msg,
      input ft_msg_vld,
      input ft_msg
   );

   modport fixed_terminal (
      input pt_msg_vld,
      input pt_msg,
      output ft_msg_vld,
      output ft_msg
   );
endinterface

// File: hdl/csw_fixed_terminal.sv
// fixed end of the cipher mode switch handshake
`timescale 1ns/10ps
module csw_fixed_terminal (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // frame timing from the burst controller
   input wire logic frame_tick,
   input wire logic [csw_pkg::FRAME_W-1:0] frame_num,
   input wire logic [csw_pkg::MFRAME_W-1:0] mframe_num,
   // upper-layer primitives
   output logic mode_switch_indication_prim,
   output logic disconnect_indication_prim,
   // cipher steering for this connection
   output logic tx_encrypt,
   output logic rx_decrypt,
   output logic rx_discard,
   output logic conn_released,
   output logic [csw_pkg::IV_W-1:0] keystream_iv,
   // air link
   csw_link_if.fixed_terminal link
);

   typedef enum logic [0:0] {
      st_idle,
      st_confirming
   } csw_ft_state_e;

   csw_ft_state_e state_q;
   logic target_q;
   logic [csw_pkg::CNT_W-1:0] cnt_q;
   logic tx_enc_q;
   logic rx_dec_q;
   logic discard_q;
   logic released_q;
   logic ind_q;
   logic dis_q;
   logic msg_vld_q;
   csw_pkg::csw_msg_e msg_q;
   logic [csw_pkg::IV_W-1:0] iv_q;

   wire frame_odd = frame_num[csw_pkg::PARITY_BIT];
   wire odd_start = frame_tick & frame_odd;
   wire even_start = frame_tick & ~frame_odd;
   // only answers, a request from the far end
   wire is_req = (link.pt_msg == csw_pkg::msg_start_req)
                 | (link.pt_msg == csw_pkg::msg_stop_req);
   wire req_enc = (link.pt_msg == csw_pkg::msg_start_req);
   // requests only accepted in even frames
   wire req_hit = (state_q == st_idle) & link.pt_msg_vld & is_req
                  & ~frame_odd & ~released_q;
   wire grant_hit = (state_q == st_confirming) & link.pt_msg_vld
                    & (link.pt_msg == csw_pkg::grant_msg(target_q));
   wire give_up = (state_q == st_confirming) & odd_start
                  & (cnt_q == csw_pkg::FT_CONF_MAX) & ~grant_hit;
   // confirms at start of odd frames
   wire send_conf = (state_q == st_confirming) & odd_start
                    & (cnt_q != csw_pkg::FT_CONF_MAX) & ~grant_hit;

   always_ff @(posedge clk_sys) begin
      if (srst || grant_hit || give_up) begin
         state_q <= st_idle;
      end else if (req_hit) begin
         state_q <= st_confirming;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         target_q <= 1'b0;
      end else if (req_hit) begin
         target_q <= req_enc;
      end
   end

   // at most six confirms, 2S+1 to 2S+11
   always_ff @(posedge clk_sys) begin
      if (srst || req_hit) begin
         cnt_q <= csw_pkg::CNT_ZERO;
      end else if (send_conf) begin
         cnt_q <= cnt_q + csw_pkg::CNT_ONE;
      end
   end

   // transmit mode switches at once on request
   // one mode shared by every bearer
   always_ff @(posedge clk_sys) begin
      if (srst || give_up) begin
         tx_enc_q <= 1'b0;
      end else if (req_hit) begin
         tx_enc_q <= req_enc;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         msg_vld_q <= 1'b0;
         msg_q <= csw_pkg::msg_on_confirm;
      end else begin
         msg_vld_q <= send_conf;
         if (send_conf) begin
            msg_q <= csw_pkg::conf_msg(target_q);
         end
      end
   end

   // old receive mode holds through 2S+1
   always_ff @(posedge clk_sys) begin
      if (srst || give_up) begin
         rx_dec_q <= 1'b0;
      end else if (grant_hit) begin
         rx_dec_q <= target_q;
      end
   end

   // discard from frame 2S+2 until the grant
   always_ff @(posedge clk_sys) begin
      if (srst || grant_hit || give_up) begin
         discard_q <= 1'b0;
      end else if ((state_q == st_confirming) && even_start) begin
         discard_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         released_q <= 1'b0;
         ind_q <= 1'b0;
         dis_q <= 1'b0;
      end else begin
         released_q <= released_q | give_up;
         ind_q <= grant_hit;
         dis_q <= give_up;
      end
   end

   // same reload value as the portable end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         iv_q <= '0;
      end else if (frame_tick) begin
         iv_q <= {csw_pkg::IV_PAD, mframe_num, frame_num};
      end
   end

   assign mode_switch_indication_prim = ind_q;
   assign disconnect_indication_prim = dis_q;
   assign tx_encrypt = tx_enc_q;
   assign rx_decrypt = rx_dec_q;
   assign rx_discard = discard_q;
   assign conn_released = released_q;
   assign keystream_iv = iv_q;
   assign link.ft_msg_vld = msg_vld_q;
   assign link.ft_msg = msg_q;

endmodule

// File: verification/csw_link_checker.sv
// concurrent checks on the portable-fixed link
`timescale 1ns/10ps
module csw_link_checker (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // frame timing
   input wire logic frame_tick,
   input wire logic half_tick,
   input wire logic [csw_pkg::FRAME_W-1:0] frame_num,
   // link
   input wire logic pt_msg_vld,
   input wire csw_pkg::csw_msg_e pt_msg,
   input wire logic ft_msg_vld,
   input wire csw_pkg::csw_msg_e ft_msg,
   // end status
   input wire logic switch_busy,
   input wire logic mode_switch_confirm_prim,
   input wire logic mode_switch_indication_prim,
   input wire logic rx_decrypt,
   input wire logic rx_discard
);
   logic pt_req;
   logic pt_grant;
   logic ft_conf;
   logic [2:0] req_cnt_d;
   logic [2:0] req_cnt_q;

   assign pt_req = pt_msg_vld && (pt_msg == csw_pkg::msg_start_req
      || pt_msg == csw_pkg::msg_stop_req);
   assign pt_grant = pt_msg_vld && (pt_msg == csw_pkg::msg_start_grant
      || pt_msg == csw_pkg::msg_stop_grant);
   assign ft_conf = ft_msg == csw_pkg::msg_on_confirm
      || ft_msg == csw_pkg::msg_off_confirm;
   // cleared while idle so each handshake counts afresh
   assign req_cnt_d = switch_busy ? req_cnt_q + {2'h0, pt_req} : 3'h0;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         req_cnt_q <= 3'h0;
      end else begin
         req_cnt_q <= req_cnt_d;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   a_pt_even_half: assert property (pt_msg_vld |->
      !frame_num[0] && $past(half_tick))
      else $error("portable message outside even second half");
   a_ft_odd_first: assert property (ft_msg_vld |->
      frame_num[0] && $past(frame_tick))
      else $error("fixed message outside odd first half");
   a_pt_codes: assert property (pt_msg_vld |-> pt_req || pt_grant)
      else $error("portable sent a fixed-side code");
   a_ft_codes: assert property (ft_msg_vld |-> ft_conf)
      else $error("fixed sent a portable-side code");
   a_req_count: assert property (req_cnt_q <= 3'h5)
      else $error("more than five requests");
   a_conf_cause: assert property ($rose(mode_switch_confirm_prim) |->
      $past(ft_msg_vld))
      else $error("confirm reported without a confirm message");
   a_conf_decrypt: assert property (mode_switch_confirm_prim |->
      !rx_discard && rx_decrypt == (ft_msg == csw_pkg::msg_on_confirm))
      else $error("receive mode wrong at confirm");
   a_req_discard: assert property (pt_req |-> ##[0:1] rx_discard)
      else $error("received data kept during request");
   a_grant_soon: assert property (mode_switch_confirm_prim |->
      ##[1:20] pt_grant)
      else $error("grant missing in next even frame");
   a_grant_ind: assert property (pt_grant |=>
      mode_switch_indication_prim)
      else $error("grant not reported at fixed end");

   c_start: cover property (mode_switch_confirm_prim && rx_decrypt);
   c_stop: cover property (mode_switch_confirm_prim && !rx_decrypt);
   c_grant: cover property (pt_grant ##1 mode_switch_indication_prim);
endmodule

// File: verification/cipher_mode_switch_handshake_tb_top.sv
// bench: both ends joined, plus one silent and one faulty far side
`timescale 1ns/10ps
module cipher_mode_switch_handshake_tb_top;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic frame_tick = 1'b0;
   logic half_tick = 1'b0;
   logic [3:0] frame_num = 4'h0;
   logic [23:0] mframe_num = 24'h0;
   logic [2:0] cyc = 3'h0;
   logic req = 1'b0;
   logic req_c = 1'b0;
   logic to_enc = 1'b0;
   int n_errors = 0;
   int checked = 0;
   logic p_conf, p_disc, p_txe, p_rxd, p_rxx, p_busy, p_rel;
   logic f_ind, f_disc, f_txe, f_rxd, f_rxx, f_rel;
   logic b_disc, b_txe, b_rxd, b_rel, c_disc, c_busy, c_rel;
   logic [csw_pkg::IV_W-1:0] p_iv, f_iv;

   csw_link_if link_a();
   csw_link_if link_b();
   csw_link_if link_c();

   always #5 clk_sys = ~clk_sys;

   // eight-cycle frames keep the timeout runs short
   always @(posedge clk_sys) begin
      cyc <= cyc + 3'h1;
      frame_tick <= #1 cyc == 3'h7;
      half_tick <= #1 cyc == 3'h3;
      if (cyc == 3'h7) begin
         frame_num <= #1 frame_num + 4'h1;
         mframe_num <= #1 mframe_num + {23'h0, frame_num == 4'hf};
      end
   end

   csw_portable_terminal u_csw_portable_terminal (
      .clk_sys(clk_sys), .srst(srst), .frame_tick(frame_tick),
      .half_tick(half_tick), .frame_num(frame_num), .mframe_num(mframe_num),
      .mode_switch_request_prim(req), .mode_switch_to_enc(to_enc),
      .mode_switch_confirm_prim(p_conf), .disconnect_indication_prim(p_disc),
      .tx_encrypt(p_txe), .rx_decrypt(p_rxd), .rx_discard(p_rxx),
      .switch_busy(p_busy), .conn_released(p_rel), .keystream_iv(p_iv),
      .link(link_a));
   csw_fixed_terminal u_csw_fixed_terminal (
      .clk_sys(clk_sys), .srst(srst), .frame_tick(frame_tick),
      .frame_num(frame_num), .mframe_num(mframe_num),
      .mode_switch_indication_prim(f_ind), .disconnect_indication_prim(f_disc),
      .tx_encrypt(f_txe), .rx_decrypt(f_rxd), .rx_discard(f_rxx),
      .conn_released(f_rel), .keystream_iv(f_iv), .link(link_a));
   // far side that requests but never grants
   csw_fixed_terminal u_csw_fixed_terminal_b (
      .clk_sys(clk_sys), .srst(srst), .frame_tick(frame_tick),
      .frame_num(frame_num), .mframe_num(mframe_num),
      .mode_switch_indication_prim(), .disconnect_indication_prim(b_disc),
      .tx_encrypt(b_txe), .rx_decrypt(b_rxd), .rx_discard(),
      .conn_released(b_rel), .keystream_iv(), .link(link_b));
   // far side that never confirms
   csw_portable_terminal u_csw_portable_terminal_c (
      .clk_sys(clk_sys), .srst(srst), .frame_tick(frame_tick),
      .half_tick(half_tick), .frame_num(frame_num), .mframe_num(mframe_num),
      .mode_switch_request_prim(req_c), .mode_switch_to_enc(to_enc),
      .mode_switch_confirm_prim(), .disconnect_indication_prim(c_disc),
      .tx_encrypt(), .rx_decrypt(), .rx_discard(), .switch_busy(c_busy),
      .conn_released(c_rel), .keystream_iv(), .link(link_c));

   csw_link_checker u_csw_link_checker (
      .clk_sys(clk_sys), .srst(srst), .frame_tick(frame_tick),
      .half_tick(half_tick), .frame_num(frame_num),
      .pt_msg_vld(link_a.pt_msg_vld), .pt_msg(link_a.pt_msg),
      .ft_msg_vld(link_a.ft_msg_vld), .ft_msg(link_a.ft_msg),
      .switch_busy(p_busy), .mode_switch_confirm_prim(p_conf),
      .mode_switch_indication_prim(f_ind), .rx_decrypt(p_rxd),
      .rx_discard(p_rxx));

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic check(input string what, input logic [34:0] seen,
      input logic [34:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      if (n_errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // iv latched at the frame start, read mid-frame
   task automatic t_iv();
      int i;
      for (i = 0; i < 10 && cyc !== 3'h3; i++) tick(1);
      check("pt iv", p_iv, {7'h0, mframe_num, frame_num});
      check("ft iv", f_iv, {7'h0, mframe_num, frame_num});
   endtask

   // request held two cycles: the second, opposite one must be dropped
   task automatic t_switch(input logic enc);
      int i;
      req = 1'b1;
      to_enc = enc;
      tick(1);
      check("busy", p_busy, 1'b1);
      to_enc = !enc;
      tick(1);
      req = 1'b0;
      for (i = 0; i < 60 && p_conf !== 1'b1; i++) tick(1);
      check("confirm", p_conf, 1'b1);
      check("pt rx mode", {p_rxd, p_rxx}, {enc, 1'b0});
      check("ft tx mode", f_txe, enc);
      for (i = 0; i < 40 && f_ind !== 1'b1; i++) tick(1);
      check("indication", f_ind, 1'b1);
      check("ft rx mode", {f_rxd, f_rxx}, {enc, 1'b0});
      check("pt tx mode", p_txe, enc);
      check("no release", {p_rel, f_rel, p_disc, f_disc}, 4'h0);
   endtask

   task automatic t_pt_timeout();
      int i;
      int n;
      n = 0;
      req_c = 1'b1;
      tick(1);
      req_c = 1'b0;
      for (i = 0; i < 200 && c_disc !== 1'b1; i++) begin
         tick(1);
         if (link_c.pt_msg_vld === 1'b1) n++;
      end
      check("pt tries", n, 5);
      check("pt disconnect", c_disc, 1'b1);
      tick(1);
      check("pt released", {c_rel, c_busy}, 2'h2);
   endtask

   task automatic t_ft_timeout();
      int i;
      int n;
      n = 0;
      for (i = 0; i < 20 && !(cyc == 3'h5 && !frame_num[0]); i++) tick(1);
      link_b.pt_msg_vld = 1'b1;
      tick(1);
      link_b.pt_msg_vld = 1'b0;
      tick(1);
      check("ft switched", b_txe, 1'b1);
      for (i = 0; i < 200 && b_disc !== 1'b1; i++) begin
         tick(1);
         if (link_b.ft_msg_vld === 1'b1) n++;
      end
      check("ft confirms", n, 6);
      check("ft disconnect", b_disc, 1'b1);
      tick(1);
      check("ft released", {b_txe, b_rxd, b_rel}, 3'h1);
   endtask

   initial begin
      link_b.pt_msg_vld = 1'b0;
      link_b.pt_msg = csw_pkg::msg_start_req;
      link_c.ft_msg_vld = 1'b0;
      link_c.ft_msg = csw_pkg::msg_on_confirm;
      tick(16);
      srst = 1'b0;
      tick(1);
      check("pt reset", {p_txe, p_rxd, p_rxx, p_busy, p_rel}, 5'h0);
      check("ft reset", {f_txe, f_rxd, f_rxx, f_rel}, 4'h0);
      t_iv();
      t_switch(1'b1);
      t_switch(1'b0);
      t_pt_timeout();
      t_ft_timeout();
      close_out();
   end

   // far beyond the few hundred cycles the run needs
   initial begin
      #20000;
      n_errors++;
      close_out();
   end
endmodule
